// [hw/pin_mux_pkg.sv]
package pin_mux_pkg;
	localparam int GPIO_COUNT = 16;
	localparam int CTRL_WIDTH = 8;
	localparam int UART_COUNT = 4;
	// fixed limits on the shared clock pin; the host keeps within them
	localparam int SPI_CLOCK_MAX_HZ = 26000000;
	localparam int I2C_CLOCK_MAX_HZ = 1000000;
	// alternate-function select bits, and the rts level bit in line control
	localparam int TX_SYNC_REFCLK_BIT = 7;
	localparam int TIMER_UPPER_OUT_BIT = 7;
	localparam int CLOCK_SOURCE_RTS_BIT = 7;
	localparam int CLOCK_SOURCE_FRAC_BIT = 3;
	localparam int LINE_CONTROL_RTS_BIT = 7;
	// gpio slots inside each group of four that carry alternate outputs
	localparam int GPIO_GROUP = 4;
	localparam int GPIO_REFCLK_SLOT = 0;
	localparam int GPIO_TIMER_SLOT = 1;

	typedef enum logic [1:0] {
		GPIO_INPUT,
		GPIO_PUSH_PULL,
		GPIO_OPEN_DRAIN,
		GPIO_EVENT
	} gpio_mode_t;

	// what an i2c address strap pin is tied to
	typedef enum logic [1:0] {
		STRAP_GND,
		STRAP_VL,
		STRAP_SCL,
		STRAP_SDA
	} strap_code_t;
endpackage : pin_mux_pkg

// [hw/gpio_pin_cell.sv]
`timescale 1ns/1ns
module gpio_pin_cell (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire logic outValue,
	input wire logic altEnable,
	input wire logic altSignal,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	output logic inValue,
	output logic eventPulse
);
	logic lastIn_reg;
	logic pinOut_next;
	logic pinOe_next;

	always_comb begin
		pinOut_next = outValue;
		pinOe_next = 1'b0;
		if (altEnable) begin // [R09] [R10]
			pinOut_next = altSignal;
			pinOe_next = 1'b1;
		end else begin // [R15]
			case (mode) // [R11]
				pin_mux_pkg::GPIO_PUSH_PULL: pinOe_next = 1'b1;
				pin_mux_pkg::GPIO_OPEN_DRAIN: begin
					pinOut_next = 1'b0;
					pinOe_next = !outValue;
				end
				default: pinOe_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinOut <= 1'b0;
			pinOe <= 1'b0;
		end else begin
			pinOut <= pinOut_next;
			pinOe <= pinOe_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lastIn_reg <= 1'b0;
			inValue <= 1'b0;
			eventPulse <= 1'b0;
		end else begin
			lastIn_reg <= pinIn;
			inValue <= pinIn;
			// any edge on a pin set up as an event source
			eventPulse <= (mode == pin_mux_pkg::GPIO_EVENT) && !altEnable
				&& (pinIn != lastIn_reg); // [R11]
		end
	end

	// rst_n in the antecedents keeps the edge that leaves reset from judging reset values
	alt_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // [R09]
		rst_n && altEnable |=> pinOe && pinOut == $past(altSignal))
		else $error("alternate output not driven");
	open_drain_a: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
		rst_n && !altEnable && mode == pin_mux_pkg::GPIO_OPEN_DRAIN
		|=> !pinOut && pinOe == !$past(outValue))
		else $error("open-drain pin drove high");
	input_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
		rst_n && !altEnable && mode == pin_mux_pkg::GPIO_INPUT |=> !pinOe)
		else $error("input pin driven");
endmodule : gpio_pin_cell

// [hw/host_port_pin_function_select.sv]
`timescale 1ns/1ns
// Contract
// R01 - strap high selects spi host port, low selects i2c; board holds the level
// R02 - shared data pin is spi output in spi mode, i2c data line in i2c mode
// R03 - shared clock pin takes spi clock to 26MHz or i2c clock to 1MHz
// R04 - strap-0 pin is active-low chip select in spi, address strap 0 in i2c
// R05 - strap-1 pin is spi data input, or address strap 1 tied to sda/scl/gnd/vl
// R06 - interrupt pin pulled low while any interrupt is pending, released otherwise
// R07 - reset input low holds all four uarts in hardware reset
// R08 - during hardware reset oscillator and pll are stopped
// R09 - gpio 0 outputs reference clock when transmit sync control bit 7 set
// R10 - gpio 1 outputs timer signal when upper timer control bit 7 set
// R11 - each gpio is input, push-pull, open-drain output or event source
// R12 - uart0 request-to-send follows the value programmed in line control
// R13 - clock source bit 7 puts system clock or divider output on request-to-send
// R14 - uart0 clear-to-send input is sampled as flow-control status
// R15 - clearing an alternate select returns the pin to its normal behaviour
module host_port_pin_function_select (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hostSelect,
	input wire logic sclkOrSclIn,
	input wire logic dataPinIn,
	output logic dataPinOut,
	output logic dataPinOe,
	input wire logic select_or_addr_strap0,
	input wire logic datain_or_addr_strap1,
	input wire logic spiMisoCore,
	input wire logic spiMisoEnable,
	input wire logic i2cSdaPullLow,
	output logic spiModeReg,
	output logic spiChipSelN,
	output logic spiClock,
	output logic spiDataIn,
	output logic i2cClock,
	output logic i2cDataIn,
	output logic [1:0] addressStrap0Reg,
	output logic [1:0] addressStrap1Reg,
	input wire logic interruptPending,
	output logic irqNOut,
	output logic irqNOe,
	output logic [pin_mux_pkg::UART_COUNT-1:0] uartResetNReg,
	output logic oscEnableReg,
	output logic pllEnableReg,
	input wire logic [pin_mux_pkg::CTRL_WIDTH-1:0] tx_sync_control,
	input wire logic [pin_mux_pkg::CTRL_WIDTH-1:0] timer_control_upper,
	input wire logic [pin_mux_pkg::CTRL_WIDTH-1:0] clock_source_control,
	input wire logic [pin_mux_pkg::CTRL_WIDTH-1:0] line_control,
	input wire logic referenceClock,
	input wire logic timerSignal,
	input wire logic uartSystemClock,
	input wire logic fracDividerOut,
	output logic request_send_out_0,
	input wire logic clear_send_in_0,
	output logic clearSendStatusReg,
	input wire logic [2*pin_mux_pkg::GPIO_COUNT-1:0] gpioMode,
	input wire logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioOutValue,
	input wire logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioPinIn,
	output logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioPinOut,
	output logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioPinOe,
	output logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioInValue,
	output logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioEvent
);
	logic refClkSel;
	logic timerSel;
	logic rtsAltSel;
	logic rtsAltSignal;

	// classify a strap pin by comparing it with the bus lines and its level
	function automatic pin_mux_pkg::strap_code_t strapCode(input logic pin,
		input logic scl, input logic sda);
		pin_mux_pkg::strap_code_t code;
		code = pin ? pin_mux_pkg::STRAP_VL : pin_mux_pkg::STRAP_GND;
		if (scl != sda) begin
			if (pin == scl)
				code = pin_mux_pkg::STRAP_SCL;
			else
				code = pin_mux_pkg::STRAP_SDA;
		end
		return code;
	endfunction : strapCode

	// reset, oscillator and pll control
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			uartResetNReg <= '0; // [R07]
			oscEnableReg <= 1'b0; // [R08]
			pllEnableReg <= 1'b0; // [R08]
		end else begin
			uartResetNReg <= '1;
			oscEnableReg <= 1'b1;
			pllEnableReg <= 1'b1;
		end
	end

	// host port mode and pin routing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			spiModeReg <= 1'b0;
			spiChipSelN <= 1'b1;
			spiClock <= 1'b0;
			spiDataIn <= 1'b0;
			i2cClock <= 1'b1;
			i2cDataIn <= 1'b1;
			dataPinOut <= 1'b0;
			dataPinOe <= 1'b0;
		end else begin
			spiModeReg <= hostSelect; // [R01]
			// clock pin feeds one protocol; the idle level goes to the other [R03]
			spiClock <= hostSelect ? sclkOrSclIn : 1'b0;
			i2cClock <= hostSelect ? 1'b1 : sclkOrSclIn;
			spiChipSelN <= hostSelect ? select_or_addr_strap0 : 1'b1; // [R04]
			spiDataIn <= hostSelect ? datain_or_addr_strap1 : 1'b0; // [R05]
			i2cDataIn <= hostSelect ? 1'b1 : dataPinIn; // [R02]
			if (spiModeReg) begin // [R02]
				dataPinOut <= spiMisoCore;
				dataPinOe <= spiMisoEnable;
			end else begin
				dataPinOut <= 1'b0;
				dataPinOe <= i2cSdaPullLow;
			end
		end
	end

	// address straps are re-read in i2c mode and frozen in spi mode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addressStrap0Reg <= pin_mux_pkg::STRAP_GND;
			addressStrap1Reg <= pin_mux_pkg::STRAP_GND;
		end else if (!hostSelect) begin
			addressStrap0Reg <= strapCode(select_or_addr_strap0, sclkOrSclIn, dataPinIn); // [R04]
			addressStrap1Reg <= strapCode(datain_or_addr_strap1, sclkOrSclIn, dataPinIn); // [R05]
		end
	end

	// open-drain interrupt
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irqNOut <= 1'b0;
			irqNOe <= 1'b0;
		end else begin
			irqNOut <= 1'b0;
			irqNOe <= interruptPending; // [R06]
		end
	end

	// uart0 flow-control pins
	assign rtsAltSel = clock_source_control[pin_mux_pkg::CLOCK_SOURCE_RTS_BIT];
	assign rtsAltSignal = clock_source_control[pin_mux_pkg::CLOCK_SOURCE_FRAC_BIT]
		? fracDividerOut : uartSystemClock;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			request_send_out_0 <= 1'b1;
			clearSendStatusReg <= 1'b1;
		end else begin
			if (rtsAltSel)
				request_send_out_0 <= rtsAltSignal; // [R13]
			else
				request_send_out_0 <= line_control[pin_mux_pkg::LINE_CONTROL_RTS_BIT]; // [R12] [R15]
			clearSendStatusReg <= clear_send_in_0; // [R14]
		end
	end

	// gpio pins; alternate outputs repeat in every group of four
	assign refClkSel = tx_sync_control[pin_mux_pkg::TX_SYNC_REFCLK_BIT];
	assign timerSel = timer_control_upper[pin_mux_pkg::TIMER_UPPER_OUT_BIT];

	for (genvar i = 0; i < pin_mux_pkg::GPIO_COUNT; i++) begin : gGpio
		localparam int SLOT = i % pin_mux_pkg::GPIO_GROUP;
		localparam bit IS_REF = (SLOT == pin_mux_pkg::GPIO_REFCLK_SLOT);
		localparam bit IS_TMR = (SLOT == pin_mux_pkg::GPIO_TIMER_SLOT);
		gpio_pin_cell uCell (
			.clock(clock),
			.rst_n(rst_n),
			.mode(gpioMode[2*i +: 2]),
			.outValue(gpioOutValue[i]),
			.altEnable((IS_REF && refClkSel) || (IS_TMR && timerSel)), // [R09] [R10]
			.altSignal(IS_REF ? referenceClock : timerSignal),
			.pinIn(gpioPinIn[i]),
			.pinOut(gpioPinOut[i]),
			.pinOe(gpioPinOe[i]),
			.inValue(gpioInValue[i]),
			.eventPulse(gpioEvent[i])
		);
	end

	uart_reset_a: assert property (@(posedge clock) !rst_n |=> uartResetNReg == '0) // [R07]
		else $error("uart left out of reset");
	clock_halt_a: assert property (@(posedge clock) // [R08]
		!rst_n |=> !oscEnableReg && !pllEnableReg)
		else $error("oscillator or pll running in reset");
	host_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // [R01]
		$past(rst_n) |-> spiModeReg == $past(hostSelect))
		else $error("host mode does not follow strap");
	// rst_n in the antecedents keeps the edge that leaves reset from judging reset values
	data_pin_a: assert property (@(posedge clock) disable iff (!rst_n) // [R02]
		rst_n && spiModeReg
		|=> dataPinOe == $past(spiMisoEnable) && dataPinOut == $past(spiMisoCore))
		else $error("spi data output misrouted");
	i2c_data_a: assert property (@(posedge clock) disable iff (!rst_n) // [R02]
		rst_n && !spiModeReg |=> !dataPinOut && dataPinOe == $past(i2cSdaPullLow))
		else $error("i2c data line misdriven");
	chip_select_a: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
		rst_n && hostSelect |=> spiChipSelN == $past(select_or_addr_strap0))
		else $error("chip select not routed");
	data_in_a: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
		rst_n && !hostSelect |=> !spiDataIn && spiChipSelN)
		else $error("spi inputs active in i2c mode");
	irq_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // [R06]
		rst_n |=> irqNOe == $past(interruptPending) && !irqNOut)
		else $error("interrupt pin does not follow pending state");
	rts_plain_a: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		rst_n && !rtsAltSel
		|=> request_send_out_0 == $past(line_control[pin_mux_pkg::LINE_CONTROL_RTS_BIT]))
		else $error("rts ignores line control");
	rts_alt_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
		rst_n && rtsAltSel |=> request_send_out_0 == $past(rtsAltSignal))
		else $error("rts misses clock output");
	cts_sample_a: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
		$past(rst_n) |-> clearSendStatusReg == $past(clear_send_in_0))
		else $error("cts status stale");

	spi_mode_c: cover property (@(posedge clock) disable iff (!rst_n) spiModeReg && !spiChipSelN);
	i2c_mode_c: cover property (@(posedge clock) disable iff (!rst_n) !spiModeReg && dataPinOe);
	rts_switch_c: cover property (@(posedge clock) disable iff (!rst_n) rtsAltSel ##1 !rtsAltSel);
	gpio_alt_c: cover property (@(posedge clock) disable iff (!rst_n) refClkSel && timerSel);
endmodule : host_port_pin_function_select

// [tb/host_bus_model.sv]
`timescale 1ns/1ns
module host_bus_model (
	input wire logic clock,
	input wire logic spiMode,
	input wire logic start,
	input wire logic devPullLow,
	output logic sclk,
	output logic csN,
	output logic mosi,
	output logic sdaLine,
	output logic busy
);
	int ph = 0;
	logic [4:0] steps = 5'h00;
	logic [7:0] sh = 8'h00;
	assign busy = steps != 5'h00;
	// clock stands still between frames: low for spi, high for i2c
	assign sclk = busy ? steps[0] : !spiMode;
	assign csN = !(spiMode && busy);
	// deselected data line shows the inverse of its first bit
	assign mosi = busy ? sh[7] : !sh[7];
	// open-drain data line with pull-up
	assign sdaLine = !devPullLow && (!busy || sh[7]);
	always @(posedge clock) begin
		if (start && !busy) begin
			steps <= 5'h10;
			sh <= 8'hA6;
			ph <= 0;
		end else if (busy) begin
			// half period of 2 cycles gives 25 MHz, of 50 cycles 1 MHz
			ph <= (ph == (spiMode ? 1 : 49)) ? 0 : ph + 1;
			if (ph == (spiMode ? 1 : 49)) begin
				steps <= steps - 5'h01;
				sh <= steps[0] ? {sh[6:0], sh[7]} : sh;
			end
		end
	end
endmodule : host_bus_model

// [tb/test_host_port_pin_function_select.sv]
`timescale 1ns/1ns
module test_host_port_pin_function_select;
	logic clock = 1'b0, rst_n = 1'b0, hostSelect = 1'b0, start = 1'b0, spiMisoEnable = 1'b0;
	logic i2cSdaPullLow = 1'b0, interruptPending = 1'b1, clear_send_in_0 = 1'b1;
	logic [1:0] t0 = 2'h0, t1 = 2'h0;
	logic [3:0] tg = 4'h0, pv, uartResetNReg;
	logic [7:0] tx_sync_control = 8'h00, timer_control_upper = 8'h00;
	logic [7:0] clock_source_control = 8'h00, line_control = 8'h00;
	logic [31:0] gpioMode = 32'h0;
	logic [15:0] gpioOutValue = 16'h0, gpioPinIn = 16'h0, gpioPinOut, gpioPinOe, gpioInValue, gpioEvent;
	logic sclk, csN, mosi, sdaLine, busy, dataPinOut, dataPinOe, spiModeReg, spiChipSelN;
	logic spiClock, spiDataIn, i2cClock, i2cDataIn, irqNOut, irqNOe, oscEnableReg, pllEnableReg;
	logic request_send_out_0, clearSendStatusReg;
	logic [1:0] addressStrap0Reg, addressStrap1Reg;
	int err_count = 0, checked = 0;
	wire referenceClock = tg[0], timerSignal = tg[1], uartSystemClock = !tg[0];
	wire fracDividerOut = tg[2], spiMisoCore = tg[1];
	// strap pins tied by the board in i2c mode: gnd, vl, scl or sda
	wire select_or_addr_strap0 = hostSelect ? csN : t0[1] ? (t0[0] ? sdaLine : sclk) : t0[0];
	wire datain_or_addr_strap1 = hostSelect ? mosi : t1[1] ? (t1[0] ? sdaLine : sclk) : t1[0];
	wire dataPinIn = hostSelect ? (dataPinOe ? dataPinOut : clock) : sdaLine;
	always #5 clock = !clock;
	always @(posedge clock) tg <= tg + 4'h1;
	host_bus_model host (.clock, .spiMode(hostSelect), .start, .devPullLow(dataPinOe && !dataPinOut),
		.sclk, .csN, .mosi, .sdaLine, .busy);
	host_port_pin_function_select dut (.clock, .rst_n, .hostSelect, .sclkOrSclIn(sclk),
		.dataPinIn, .dataPinOut, .dataPinOe, .select_or_addr_strap0, .datain_or_addr_strap1,
		.spiMisoCore, .spiMisoEnable, .i2cSdaPullLow, .spiModeReg, .spiChipSelN, .spiClock,
		.spiDataIn, .i2cClock, .i2cDataIn, .addressStrap0Reg, .addressStrap1Reg,
		.interruptPending, .irqNOut, .irqNOe, .uartResetNReg, .oscEnableReg, .pllEnableReg,
		.tx_sync_control, .timer_control_upper, .clock_source_control, .line_control,
		.referenceClock, .timerSignal, .uartSystemClock, .fracDividerOut, .request_send_out_0,
		.clear_send_in_0, .clearSendStatusReg, .gpioMode, .gpioOutValue, .gpioPinIn,
		.gpioPinOut, .gpioPinOe, .gpioInValue, .gpioEvent);
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	// one clock later, with pv holding the toggling sources as sampled
	task automatic cyc();
		@(posedge clock);
		#1;
		pv = tg - 4'h1;
	endtask : cyc
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic reset_test();
		repeat (19) @(posedge clock);
		#1;
		chk({uartResetNReg, oscEnableReg, pllEnableReg, irqNOe, request_send_out_0}, 8'h01);
		@(posedge clock);
		rst_n <= 1'b1;
		cyc;
		chk({uartResetNReg, oscEnableReg, pllEnableReg, irqNOe, irqNOut}, 8'hFE);
		@(posedge clock);
		interruptPending <= 1'b0;
		cyc;
		chk(irqNOe, 1'b0);
		$display("test reset_irq done");
	endtask : reset_test
	task automatic i2c_run(input logic [1:0] a, input logic [1:0] b);
		logic s;
		logic d;
		@(posedge clock);
		hostSelect <= 1'b0;
		t0 <= a;
		t1 <= b;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		cyc;
		while (busy) begin
			@(negedge clock);
			s = sclk;
			d = sdaLine;
			cyc;
			// lines apart: a bus-tied strap is exact, a fixed level reads as the line it equals
			chk(addressStrap0Reg, s == d ? (a[1] ? {1'b0, s} : a) : a[1] ? a : {1'b1, a[0] != s});
			chk(addressStrap1Reg, s == d ? (b[1] ? {1'b0, s} : b) : b[1] ? b : {1'b1, b[0] != s});
			chk({i2cClock, i2cDataIn, spiModeReg, spiChipSelN, dataPinOe}, {s, d, 3'h2});
		end
		@(posedge clock);
		i2cSdaPullLow <= 1'b1;
		cyc;
		chk({dataPinOe, dataPinOut}, 2'h2);
		cyc;
		chk(i2cDataIn, 1'b0);
		@(posedge clock);
		i2cSdaPullLow <= 1'b0;
		repeat (3) cyc;
		$display("test i2c done");
	endtask : i2c_run
	task automatic spi_run();
		logic [3:0] p;
		@(posedge clock);
		hostSelect <= 1'b1;
		spiMisoEnable <= 1'b1;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		cyc;
		while (busy) begin
			@(negedge clock);
			p = {csN, sclk, mosi, spiMisoCore};
			cyc;
			chk({spiChipSelN, spiClock, spiDataIn, dataPinOut}, p);
			chk({dataPinOe, spiModeReg, i2cClock, i2cDataIn}, 4'hF);
			chk({addressStrap0Reg, addressStrap1Reg}, 4'h4);
		end
		$display("test spi done");
	endtask : spi_run
	task automatic rts_test();
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			clock_source_control <= {i[1], 3'h0, i[0], 3'h0};
			line_control <= {i[2] ^ i[0], 7'h00};
			clear_send_in_0 <= i[0];
			repeat (3) begin
				cyc;
				chk(request_send_out_0, i[1] ? (i[0] ? pv[2] : !pv[0]) : i[2] ^ i[0]);
				chk(clearSendStatusReg, i[0]);
			end
		end
		$display("test rts_cts done");
	endtask : rts_test
	task automatic gpio_test();
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			gpioMode <= {16{m[1:0]}};
			gpioOutValue <= 16'hA5C3;
			gpioPinIn <= 16'h3C5A;
			cyc;
			chk(gpioPinOe, m == 1 ? 16'hFFFF : m == 2 ? 16'h5A3C : 16'h0000);
			chk(gpioInValue, 16'h3C5A);
			if (m[0] ^ m[1])
				chk(gpioPinOut, m == 1 ? 16'hA5C3 : 16'h0000);
		end
		@(posedge clock);
		gpioPinIn <= 16'h3C5E;
		cyc;
		chk(gpioEvent, 16'h0004);
		cyc;
		chk(gpioEvent, 16'h0000);
		@(posedge clock);
		gpioMode <= {16{2'h1}};
		tx_sync_control <= 8'h80;
		timer_control_upper <= 8'h80;
		repeat (4) begin
			cyc;
			chk(gpioPinOut, 16'hA5C3 & 16'hCCCC | {4{2'h0, pv[1], pv[0]}});
		end
		@(posedge clock);
		tx_sync_control <= 8'h00;
		timer_control_upper <= 8'h00;
		cyc;
		cyc;
		chk(gpioPinOut, 16'hA5C3);
		$display("test gpio done");
	endtask : gpio_test
	initial begin
		reset_test();
		for (int k = 0; k < 4; k++)
			i2c_run(k[1:0], 2'h3 - k[1:0]);
		spi_run();
		rts_test();
		gpio_test();
		@(posedge clock);
		rst_n <= 1'b0;
		cyc;
		chk({uartResetNReg, oscEnableReg, pllEnableReg}, 6'h00);
		@(posedge clock);
		rst_n <= 1'b1;
		cyc;
		chk({uartResetNReg, oscEnableReg, pllEnableReg}, 6'h3F);
		$display("test reset_again done");
		wrap_up();
	end
	// the tests need some 3300 cycles; allow twice that and more
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
endmodule : test_host_port_pin_function_select
